// ### rtl/fpu_align_params.svh
/*
  Constants for the floating-point pipeline alignment block.
  Assumes inclusion by bare name from the package and the design files.
*/
`ifndef FPU_ALIGN_PARAMS_SVH
`define FPU_ALIGN_PARAMS_SVH
// --------------------------------------------------------------
// Instruction classes on the issue_class input
// --------------------------------------------------------------
`define CLS_HOST 4'h0
`define CLS_SINGLE 4'h1
`define CLS_MATH 4'h2
`define CLS_CONV 4'h3
`define CLS_HOST_TO_FPU 4'h4
`define CLS_FPU_TO_HOST 4'h5
`define CLS_PAR_MATH_MOVE 4'h6
`define CLS_PAR_MATH_MATH 4'h7
`define CLS_FRAC 4'h8
// --------------------------------------------------------------
// Timing, in issue slots, and register index width
// --------------------------------------------------------------
`define SINGLE_LAT 2'h1
`define PIPE_LAT 2'h2
`define H2F_SLOTS 3'h4
`define F2H_GAP_SINGLE 2'h1
`define F2H_GAP_PIPE 2'h2
`define REG_IDX_W 3
`endif

// ### rtl/fpu_align_pkg.sv
/*
  Types for the floating-point pipeline alignment block.
  Assumes fpu_align_params.svh is on the include path.
*/
package fpu_align_pkg;
  `include "fpu_align_params.svh"
  typedef enum logic [1:0] {
    ROUTE_NONE = 2'b00,
    ROUTE_HOST = 2'b01,
    ROUTE_FPU = 2'b10
  } route_t;
endpackage

// ### rtl/fpu_result_slot.sv
/*
  One result lane: holds a destination until its result becomes valid.
  Assumes the caller gives an issue advance enable shared with the host pipeline.
*/
`timescale 1ns/100ps
`include "fpu_align_params.svh"
module fpu_result_slot #(
  parameter int IDX_W = `REG_IDX_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic advance,
  input wire logic start,
  input wire logic [1:0] latency,
  input wire logic [IDX_W-1:0] dest,
  output logic done,
  output logic [IDX_W-1:0] done_dest,
  output logic busy
);
  logic [1:0] remain;
  logic [IDX_W-1:0] held;
  // A pending pipelined result keeps priority over a new single one on the same edge
  wire last = (remain == 2'h1);
  wire [1:0] next_remain = start ? (latency - 2'h1) : (remain != 2'h0 ? remain - 2'h1 : 2'h0);
  wire next_done = last || (start && (latency == 2'h1));
  wire [IDX_W-1:0] next_done_dest = last ? held : dest;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      remain <= 2'h0;
      held <= '0;
      done <= 1'b0;
      done_dest <= '0;
    end else if (advance) begin
      remain <= next_remain;
      if (start) begin
        held <= dest;
      end
      done <= next_done;
      done_dest <= next_done_dest;
    end else begin
      done <= 1'b0;
    end
  end
  assign busy = (remain != 2'h0);
endmodule

// ### rtl/fpu_pipeline_alignment.sv
/*
  Alignment control for a floating-point unit sharing the host CPU pipeline.
  Assumes the host decoder presents one classified instruction per issue slot and
  that the instruction stream respects all delay slots; only shared clk and rst_n.
*/
`timescale 1ns/100ps
`include "fpu_align_params.svh"
module fpu_pipeline_alignment #(
  parameter int IDX_W = `REG_IDX_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic issue_valid,
  input wire logic [3:0] issue_class,
  input wire logic [IDX_W-1:0] dest_a,
  input wire logic [IDX_W-1:0] dest_b,
  input wire logic [IDX_W-1:0] src_reg,
  input wire logic decode_stall,
  input wire logic mem_wait,
  output logic [1:0] route,
  output logic fpu_advance,
  output logic result_a_valid,
  output logic [IDX_W-1:0] result_a_dest,
  output logic result_b_valid,
  output logic [IDX_W-1:0] result_b_dest,
  output logic f2h_ready,
  output logic h2f_ready,
  output logic slot_violation
);
  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  function automatic logic is_pipe(input logic [3:0] c);
    is_pipe = (c == `CLS_MATH) || (c == `CLS_CONV) || (c == `CLS_PAR_MATH_MOVE) ||
              (c == `CLS_PAR_MATH_MATH);
  endfunction
  wire advance = !(decode_stall || mem_wait);
  wire take = issue_valid && advance;
  wire is_host = (issue_class == `CLS_HOST) || (issue_class == `CLS_FPU_TO_HOST);
  wire [1:0] next_route = !take ? fpu_align_pkg::ROUTE_NONE :
    (is_host ? fpu_align_pkg::ROUTE_HOST : fpu_align_pkg::ROUTE_FPU);
  // Lane a carries the math half; the move half of 2p/1 goes single on lane b
  wire start_a = take && !is_host && (issue_class != `CLS_HOST_TO_FPU);
  wire [1:0] lat_a = is_pipe(issue_class) ? `PIPE_LAT : `SINGLE_LAT;
  wire start_b = take && ((issue_class == `CLS_PAR_MATH_MOVE) ||
    (issue_class == `CLS_PAR_MATH_MATH));
  wire [1:0] lat_b = (issue_class == `CLS_PAR_MATH_MATH) ? `PIPE_LAT : `SINGLE_LAT;
  // ------------------------------------------------------------
  // Result lanes
  // ------------------------------------------------------------
  fpu_result_slot #(.IDX_W(IDX_W)) lane_a (
    .clk(clk),
    .rst_n(rst_n),
    .advance(advance),
    .start(start_a),
    .latency(lat_a),
    .dest(dest_a),
    .done(result_a_valid),
    .done_dest(result_a_dest),
    .busy()
  );
  fpu_result_slot #(.IDX_W(IDX_W)) lane_b (
    .clk(clk),
    .rst_n(rst_n),
    .advance(advance),
    .start(start_b),
    .latency(lat_b),
    .dest(dest_b),
    .done(result_b_valid),
    .done_dest(result_b_dest),
    .busy()
  );
  // ------------------------------------------------------------
  // Move alignment tracking
  // ------------------------------------------------------------
  // Slots since last float write of each register, saturating
  logic [1:0] write_age [2**IDX_W];
  logic [1:0] write_need [2**IDX_W];
  logic [2:0] h2f_count;
  logic [IDX_W-1:0] h2f_dest;
  wire is_f2h = take && (issue_class == `CLS_FPU_TO_HOST);
  wire is_h2f = take && (issue_class == `CLS_HOST_TO_FPU);
  wire f2h_ok = (write_age[src_reg] >= write_need[src_reg]);
  wire in_h2f_window = (h2f_count != 3'h0);
  wire uses_h2f_reg = (src_reg == h2f_dest) && !is_host;
  wire forbidden = (issue_class == `CLS_FRAC) || (issue_class == `CLS_CONV);
  wire next_violation = take && ((is_f2h && !f2h_ok) ||
    (in_h2f_window && (forbidden || uses_h2f_reg)));
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 2**IDX_W; i++) begin
        write_age[i] <= 2'h3;
        write_need[i] <= 2'h0;
      end
    end else if (advance) begin
      // An advancing slot without an issue counts as a bubble slot
      for (int i = 0; i < 2**IDX_W; i++) begin
        if (write_age[i] != 2'h3) begin
          write_age[i] <= write_age[i] + 2'h1;
        end
      end
      if (start_a) begin
        write_age[dest_a] <= 2'h0;
        write_need[dest_a] <= is_pipe(issue_class) ? `F2H_GAP_PIPE : `F2H_GAP_SINGLE;
      end
      if (start_b) begin
        write_age[dest_b] <= 2'h0;
        write_need[dest_b] <= (lat_b == `PIPE_LAT) ? `F2H_GAP_PIPE : `F2H_GAP_SINGLE;
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      h2f_count <= 3'h0;
      h2f_dest <= '0;
    end else if (advance) begin
      if (is_h2f) begin
        h2f_count <= `H2F_SLOTS;
        h2f_dest <= dest_a;
      end else if (in_h2f_window) begin
        h2f_count <= h2f_count - 3'h1;
      end
    end
  end
  // Flag only: no interlock, the stream owns the hazard
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      route <= fpu_align_pkg::ROUTE_NONE;
      slot_violation <= 1'b0;
    end else begin
      route <= next_route;
      slot_violation <= next_violation;
    end
  end
  assign fpu_advance = advance;
  assign f2h_ready = f2h_ok;
  assign h2f_ready = !in_h2f_window;
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_stall_freezes: assert property (@(posedge clk) disable iff (!rst_n)
    (decode_stall || mem_wait) |-> !fpu_advance)
    else $error("FPU advanced during a host stall");
  a_route_host: assert property (@(posedge clk) disable iff (!rst_n)
    (take && issue_class == `CLS_HOST) |=> route == fpu_align_pkg::ROUTE_HOST)
    else $error("Host instruction not routed to host");
  a_route_fpu: assert property (@(posedge clk) disable iff (!rst_n)
    (take && issue_class == `CLS_MATH) |=> route == fpu_align_pkg::ROUTE_FPU)
    else $error("Float instruction not routed to float unit");
  a_single_done: assert property (@(posedge clk) disable iff (!rst_n)
    (take && issue_class == `CLS_SINGLE) |=> result_a_valid)
    else $error("Single-cycle result not valid next slot");
  a_pipe_done: assert property (@(posedge clk) disable iff (!rst_n)
    (take && issue_class == `CLS_MATH ##1 advance) |=> result_a_valid && result_a_dest == $past(dest_a, 2))
    else $error("Pipelined result not valid one issue later");
  a_conv_not_early: assert property (@(posedge clk) disable iff (!rst_n)
    (take && issue_class == `CLS_CONV) |=> !result_a_valid)
    else $error("Conversion result valid too early");
  a_par_move_one: assert property (@(posedge clk) disable iff (!rst_n)
    (take && issue_class == `CLS_PAR_MATH_MOVE) |=> result_b_valid && !result_a_valid)
    else $error("Parallel move not single cycle");
  a_par_math_two: assert property (@(posedge clk) disable iff (!rst_n)
    (take && issue_class == `CLS_PAR_MATH_MATH ##1 advance) |=> result_a_valid && result_b_valid)
    else $error("Dual math results not aligned");
  a_h2f_window: assert property (@(posedge clk) disable iff (!rst_n)
    (take && issue_class == `CLS_HOST_TO_FPU) |=> !h2f_ready)
    else $error("Host-to-float window not opened");
  a_f2h_pipe_gap: assert property (@(posedge clk) disable iff (!rst_n)
    (take && issue_class == `CLS_MATH && !start_b) |=> !f2h_ready || src_reg != $past(dest_a))
    else $error("Float-to-host move allowed too soon after pipelined write");
  a_pipe_back_to_back: assert property (@(posedge clk) disable iff (!rst_n)
    (take && issue_class == `CLS_MATH ##1 take && issue_class == `CLS_MATH ##1 advance) |=>
    result_a_valid && result_a_dest == $past(dest_a, 2))
    else $error("Back-to-back pipelined result lost");
  a_f2h_single_gap: assert property (@(posedge clk) disable iff (!rst_n)
    (take && issue_class == `CLS_SINGLE) |=> !f2h_ready || src_reg != $past(dest_a))
    else $error("Float-to-host move allowed right after single-cycle write");
endmodule

// ### verif/host_stall_model.sv
/*
  Model of the host pipeline stall sources: decode stalls and memory waits.
  Assumes the bench pulses start for one cycle together with an issue.
*/
`timescale 1ns/100ps
module host_stall_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic kind,
  input wire logic [3:0] len,
  output logic decode_stall,
  output logic mem_wait
);
  // ----------------------------------------
  // Stall counter
  // ----------------------------------------
  logic [3:0] cnt;
  logic sel;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 4'h0;
      sel <= 1'b0;
    end else if (start) begin
      cnt <= len;
      sel <= kind;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end
  end
  // Either source stalls the host, so the float side must freeze alike
  assign decode_stall = (cnt != 4'h0) && sel;
  assign mem_wait = (cnt != 4'h0) && !sel;
endmodule

// ### verif/fpu_pipeline_alignment_tb_top.sv
/*
  Self-checking bench for the float pipeline alignment block.
  Assumes the stall model drives the host stall inputs.
*/
`timescale 1ns/100ps
module fpu_pipeline_alignment_tb_top;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk = 1'b0, rst_n = 1'b0, issue_valid = 1'b0, start = 1'b0, kind = 1'b0;
  logic [3:0] issue_class = 4'h0, len = 4'h0;
  logic [2:0] dest_a = 3'h0, dest_b = 3'h0, src_reg = 3'h0;
  logic decode_stall, mem_wait, fpu_advance, result_a_valid, result_b_valid;
  logic f2h_ready, h2f_ready, slot_violation;
  logic [1:0] route;
  logic [2:0] result_a_dest, result_b_dest;
  int error_cnt = 0, num_checks = 0;
  logic [3:0] cls_tab [6] = '{4'h1, 4'h2, 4'h3, 4'h6, 4'h7, 4'h8};
  fpu_pipeline_alignment u_fpu_pipeline_alignment (.clk(clk), .rst_n(rst_n), .issue_valid(issue_valid),
    .issue_class(issue_class), .dest_a(dest_a), .dest_b(dest_b), .src_reg(src_reg),
    .decode_stall(decode_stall), .mem_wait(mem_wait), .route(route), .fpu_advance(fpu_advance),
    .result_a_valid(result_a_valid), .result_a_dest(result_a_dest), .result_b_valid(result_b_valid),
    .result_b_dest(result_b_dest), .f2h_ready(f2h_ready), .h2f_ready(h2f_ready),
    .slot_violation(slot_violation));
  host_stall_model u_host_stall_model (.clk(clk), .rst_n(rst_n), .start(start), .kind(kind), .len(len),
    .decode_stall(decode_stall), .mem_wait(mem_wait));
  initial begin
    forever #10 clk = ~clk;
  end
  // ----------------------------------------
  // Expectations and checks
  // ----------------------------------------
  function automatic int lat_a(input logic [3:0] c);
    return (c == 4'h1 || c == 4'h8) ? 1 : (c == 4'h2 || c == 4'h3 || c == 4'h6 || c == 4'h7) ? 2 : 0;
  endfunction
  function automatic int lat_b(input logic [3:0] c);
    return (c == 4'h6) ? 1 : (c == 4'h7) ? 2 : 0;
  endfunction
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // One issue, then idle slots so the stream keeps every delay slot
  task automatic op(input logic [3:0] c, input logic [2:0] a, input logic [2:0] b, input logic st);
    int la;
    int lb;
    la = lat_a(c);
    lb = lat_b(c);
    @(posedge clk);
    issue_valid <= 1'b1;
    issue_class <= c;
    dest_a <= a;
    dest_b <= b;
    src_reg <= a;
    start <= st;
    len <= 4'h3;
    kind <= $urandom % 2;
    // A single result leaves on the issue edge, before the stall begins
    if (st) begin
      if (la > 1) la = la + 3;
      lb = 0;
    end
    for (int k = 1; k <= 7; k++) begin
      @(posedge clk);
      issue_valid <= 1'b0;
      start <= 1'b0;
      #1;
      if (k == 1) chk("route", route, (c == 4'h0) ? 8'h01 : 8'h02);
      if (st) chk("fpu_advance", fpu_advance, k >= 4);
      chk("result_a_valid", result_a_valid, la == k);
      if (la == k) chk("result_a_dest", result_a_dest, a);
      chk("result_b_valid", result_b_valid, lb == k);
      if (lb == k) chk("result_b_dest", result_b_dest, b);
      if (la > 0 && !st) chk("f2h_ready", f2h_ready, k > la);
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [2:0] r;
    void'($urandom(80800));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    op(4'h0, 3'h1, 3'h2, 1'b0);
    for (int i = 0; i < 6; i++) op(cls_tab[i], 3'h5, 3'h2, 1'b0);
    op(4'h2, 3'h6, 3'h1, 1'b1);
    op(4'h1, 3'h4, 3'h0, 1'b1);
    for (int i = 0; i < 20; i++) begin
      r = $urandom;
      op(cls_tab[$urandom % 6], r, r ^ (3'h1 + 3'($urandom % 7)), 1'b0);
    end
    // Four quiet slots after a host-to-float move keep the stream legal
    @(posedge clk);
    issue_valid <= 1'b1;
    issue_class <= 4'h4;
    dest_a <= 3'h3;
    for (int k = 0; k <= 4; k++) begin
      @(posedge clk);
      issue_valid <= 1'b0;
      #1;
      chk("h2f_ready", h2f_ready, k == 4);
    end
    // Move right behind a pipelined write of its source: flagged, never stalled
    @(posedge clk);
    issue_valid <= 1'b1;
    issue_class <= 4'h2;
    dest_a <= 3'h3;
    @(posedge clk);
    issue_class <= 4'h5;
    src_reg <= 3'h3;
    @(posedge clk);
    issue_valid <= 1'b0;
    #1;
    chk("slot_violation", slot_violation, 8'h01);
    chk("fpu_advance", fpu_advance, 8'h01);
    wrap_up();
  end
endmodule
